//--- inc/pkt_fifo_map.vh
// constants for the packet buffer and pattern recognizer
// assumes inclusion by the packet buffer design files, its checker and its testbench
`ifndef PKT_FIFO_MAP_VH
`define PKT_FIFO_MAP_VH

`define FIFO_DEPTH        64
`define FIFO_PTR_W        6
`define FIFO_CNT_W        7
`define BYTE_MSB          7
`define PAT_W             64
`define PAT_LEN_W         3

`define MODE_W            3
`define MODE_SLEEP        3'h0
`define MODE_STANDBY      3'h1
`define MODE_TX           3'h3
`define MODE_RX           3'h5

`define BIT_CNT_LAST      3'h7
`define FRAME_PRE_BYTES   4'h3
`define PREAMBLE_BYTE     8'hAA
`define SETTLE_TIME_NS    100
`define SYS_CLK_MHZ       40
// settle time in whole sys_clk cycles, rounded up, sized for the counter
`define SETTLE_CYCLES     8'h04

`endif

//--- sim/pfsd_chk.sv
// checker: flag, mode and pattern relations of the packet buffer
// assumes it is bound onto the packet buffer top module
`timescale 1ns/1ps
`include "pkt_fifo_map.vh"

module pfsd_chk (
    input wire                 sys_clk,
    input wire                 sys_rst,
    input wire [`MODE_W-1:0]   chip_mode,
    input wire                 host_wr,
    input wire                 host_rd,
    input wire                 spi_cs_n,
    input wire                 overflow_clear,
    input wire [5:0]           level_threshold,
    input wire                 pattern_detect_enable,
    input wire                 buffer_drained,
    input wire                 buffer_full_flag,
    input wire                 buffer_overflow_flag,
    input wire                 buffer_level_flag,
    input wire                 frame_transmitted,
    input wire                 pattern_match_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    wire idle  = !host_wr && !host_rd && !overflow_clear;
    wire quiet = chip_mode == `MODE_STANDBY || chip_mode == `MODE_SLEEP;

    a_full_not_drained: assert property (
        buffer_full_flag |-> !buffer_drained)
        else $error("full and drained at once");
    a_overflow_on_full: assert property (
        host_wr && buffer_full_flag && quiet && !overflow_clear
        |=> buffer_overflow_flag) else $error("overflow not flagged");
    a_clear_flushes: assert property (
        overflow_clear && !host_wr && spi_cs_n
        |=> !buffer_overflow_flag && buffer_drained)
        else $error("overflow clear did not flush");
    // chip select reaches the flag through two sync stages
    a_write_fills: assert property (
        host_wr && quiet && $stable(chip_mode) && spi_cs_n &&
        $past(spi_cs_n, 2) && !overflow_clear
        |=> !buffer_drained) else $error("drained after a write");
    // a lagging compare one cycle after an access is tolerated
    a_level_holds: assert property (
        idle && $past(idle) && quiet && $stable(chip_mode)
        && $changed(level_threshold) |=> $stable(buffer_level_flag))
        else $error("level moved on threshold change alone");
    a_frame_pulse: assert property (
        frame_transmitted |-> buffer_drained ##1 !frame_transmitted)
        else $error("frame pulse wrong");
    a_match_enabled: assert property (
        $rose(pattern_match_flag)
        |-> pattern_detect_enable && chip_mode == `MODE_RX)
        else $error("match without enable in receive");
    a_match_leave: assert property (
        $past(chip_mode) == `MODE_RX && chip_mode != `MODE_RX
        |-> ##[1:4] !pattern_match_flag)
        else $error("match kept after receive left");
    a_rx_entry_flush: assert property (
        $past(chip_mode) == `MODE_STANDBY && chip_mode == `MODE_RX
        && spi_cs_n |-> ##[1:4] buffer_drained)
        else $error("buffer kept on entering receive");

    c_full: cover property (buffer_full_flag);
    c_overflow: cover property ($rose(buffer_overflow_flag));
    c_match: cover property ($rose(pattern_match_flag));
    c_sent: cover property (frame_transmitted);
endmodule // pfsd_chk

bind packet_fifo_sync_detect pfsd_chk i_pfsd_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .chip_mode(chip_mode),
    .host_wr(host_wr), .host_rd(host_rd), .spi_cs_n(spi_cs_n),
    .overflow_clear(overflow_clear), .level_threshold(level_threshold),
    .pattern_detect_enable(pattern_detect_enable),
    .buffer_drained(buffer_drained), .buffer_full_flag(buffer_full_flag),
    .buffer_overflow_flag(buffer_overflow_flag),
    .buffer_level_flag(buffer_level_flag),
    .frame_transmitted(frame_transmitted),
    .pattern_match_flag(pattern_match_flag));

//--- sim/radio_side.sv
// radio-side model: bit-rate strobes, demodulated bits, tx capture
// assumes the buffer samples demod_bit on bit_tick after two sync flops
`timescale 1ns/1ps

module radio_side #(
    parameter logic [15:0] TX_MATCH = 16'h0000
) (
    input  wire   sys_clk,
    input  wire   sys_rst,
    input  wire   mod_bit,
    output logic  bit_tick,
    output logic  demod_bit,
    output logic  tx_seen,
    output logic  rx_busy
);
    logic [7:0]  rx_q[$];
    logic [7:0]  cur;
    logic [15:0] win;
    int          div;
    int          nb;

    initial begin
        bit_tick = 0;
        demod_bit = 0;
        rx_busy = 0;
        div = 0;
        nb = 0;
    end

    task automatic load(input logic [7:0] b);
        rx_q.push_back(b);
    endtask

    // data moves mid-period so it is settled well before the strobe
    always @(negedge sys_clk) begin
        div <= (div + 1) % 8;
        bit_tick <= div == 7;
        if (div == 3) begin
            if (nb == 0 && rx_q.size() != 0) begin
                cur = rx_q.pop_front();
                nb = 8;
            end
            if (nb != 0) begin
                demod_bit <= cur[7];
                cur = cur << 1;
                nb = nb - 1;
            end else
                demod_bit <= ~demod_bit; // idle toggling never forms a match
        end
        rx_busy <= rx_q.size() != 0 || nb != 0;
    end

    always @(posedge sys_clk)
        if (sys_rst) begin
            win <= 16'h0000;
            tx_seen <= 1'b0;
        end else if (bit_tick) begin
            win <= {win[14:0], mod_bit};
            if ({win[14:0], mod_bit} == TX_MATCH)
                tx_seen <= 1'b1;
        end
endmodule // radio_side

//--- sim/test_packet_fifo_sync_detect.sv
// self-checking bench for the packet buffer and pattern recognizer
// assumes the radio-side model and the bound checker
`timescale 1ns/1ps
`include "pkt_fifo_map.vh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end end

module test_packet_fifo_sync_detect;
    logic              sys_clk = 0, sys_rst = 1;
    logic [2:0]        chip_mode, pattern_length;
    logic              host_wr, host_rd, spi_cs_n, overflow_clear;
    logic [7:0]        host_wdata, exp_b;
    logic [5:0]        level_threshold;
    logic              pattern_detect_enable, rd_taken;
    logic [63:0]       pattern_value;
    wire  [7:0]        host_rdata;
    wire               mod_bit, buffer_drained, buffer_full_flag;
    wire               buffer_overflow_flag, buffer_level_flag;
    wire               frame_transmitted, pattern_match_flag;
    wire               mode_settled_flag, bit_tick, demod_bit;
    wire               tx_seen, rx_busy, bit_sync_enable;
    logic [7:0]        fill [64];
    logic [7:0]        exp_q[$];
    int                error_cnt = 0, samples_checked = 0, cyc = 0;

    always #12.5 sys_clk = ~sys_clk;

    packet_fifo_sync_detect i_packet_fifo_sync_detect (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .chip_mode(chip_mode), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_rd(host_rd), .spi_cs_n(spi_cs_n),
        .overflow_clear(overflow_clear), .level_threshold(level_threshold),
        .bit_tick(bit_tick), .demod_bit(demod_bit),
        .pattern_detect_enable(pattern_detect_enable),
        .pattern_length(pattern_length), .pattern_value(pattern_value),
        .host_rdata(host_rdata), .mod_bit(mod_bit),
        .buffer_drained(buffer_drained), .buffer_full_flag(buffer_full_flag),
        .buffer_overflow_flag(buffer_overflow_flag),
        .buffer_level_flag(buffer_level_flag),
        .frame_transmitted(frame_transmitted),
        .pattern_match_flag(pattern_match_flag),
        .mode_settled_flag(mode_settled_flag),
        .bit_sync_enable(bit_sync_enable));

    radio_side #(.TX_MATCH(16'hD3C5)) radio (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .mod_bit(mod_bit), .bit_tick(bit_tick),
        .demod_bit(demod_bit), .tx_seen(tx_seen), .rx_busy(rx_busy));

    task automatic final_report();
        $display("mismatches %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge sys_clk)
        if (++cyc == 10000) begin
            error_cnt++;
            final_report();
        end

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] b);
        host_wr = 1;
        host_wdata = b;
        step(1);
        host_wr = 0;
        step(1);
    endtask
    // chip select falls first so the drained flag has resynchronised
    task automatic rd(input logic [7:0] e);
        spi_cs_n = 0;
        step(4);
        host_rd = 1;
        exp_q.push_back(e);
        step(1);
        host_rd = 0;
        spi_cs_n = 1;
        step(1);
    endtask
    task automatic chk_drained(input logic e);
        spi_cs_n = 0;
        step(4);
        `CHK("drained", e, buffer_drained)
        spi_cs_n = 1;
        step(1);
    endtask
    task automatic mode(input logic [2:0] m);
        chip_mode = m;
        step(1);
        for (int i = 0; i < 50 && mode_settled_flag !== 1'b1; i++) step(1);
        `CHK("settled", 1'b1, mode_settled_flag)
    endtask
    task automatic flush();
        overflow_clear = 1;
        step(1);
        overflow_clear = 0;
        step(1);
    endtask

    always @(posedge sys_clk) rd_taken <= host_rd;
    always @(negedge sys_clk)
        if (rd_taken === 1'b1) begin
            exp_b = exp_q.pop_front();
            `CHK("rdata", exp_b, host_rdata)
        end

    initial begin
        chip_mode = `MODE_STANDBY;
        {host_wr, host_rd, overflow_clear, host_wdata} = 0;
        spi_cs_n = 1;
        level_threshold = 6'h02;
        pattern_detect_enable = 0;
        pattern_length = 3'h0;
        pattern_value = {8{8'hD3}};
        void'($urandom(32'h76AD5D95));
        step(12);
        sys_rst = 0;
        step(1);
        `CHK("drained", 1'b1, buffer_drained)
        wr(8'h11);
        wr(8'h22);
        `CHK("level", 1'b0, buffer_level_flag)
        wr(8'h33);
        `CHK("level", 1'b1, buffer_level_flag)
        level_threshold = 6'h05;
        step(3);
        `CHK("level", 1'b1, buffer_level_flag)
        rd(8'h11);
        `CHK("level", 1'b0, buffer_level_flag)
        flush();
        `CHK("drained", 1'b1, buffer_drained)
        for (int i = 0; i < 64; i++) begin
            fill[i] = $urandom;
            if (i == 63) `CHK("full", 1'b0, buffer_full_flag)
            wr(fill[i]);
        end
        `CHK("full", 1'b1, buffer_full_flag)
        wr(~fill[0]);
        `CHK("overflow", 1'b1, buffer_overflow_flag)
        for (int i = 0; i < 64; i++) rd(fill[i]);
        chk_drained(1'b1);
        `CHK("level", 1'b0, buffer_level_flag)
        `CHK("full", 1'b0, buffer_full_flag)
        `CHK("overflow", 1'b1, buffer_overflow_flag)
        wr(8'h5A);
        flush();
        `CHK("overflow", 1'b0, buffer_overflow_flag)
        `CHK("drained", 1'b1, buffer_drained)
        wr(8'h77);
        mode(`MODE_SLEEP);
        mode(`MODE_STANDBY);
        `CHK("drained", 1'b0, buffer_drained)
        pattern_detect_enable = 1;
        mode(`MODE_RX);
        `CHK("drained", 1'b1, buffer_drained)
        `CHK("bit sync", 1'b1, bit_sync_enable)
        radio.load(8'hD3);
        radio.load(8'h96);
        radio.load(8'h3C);
        step(2);
        for (int i = 0; i < 2000 && rx_busy; i++) step(1);
        @(posedge bit_tick);
        step(4);
        `CHK("match", 1'b1, pattern_match_flag)
        mode(`MODE_STANDBY);
        `CHK("match", 1'b0, pattern_match_flag)
        rd(8'h96);
        rd(8'h3C);
        chk_drained(1'b1);
        wr(8'hC5);
        mode(`MODE_TX);
        for (int i = 0; i < 3000 && frame_transmitted !== 1'b1; i++) step(1);
        `CHK("sent", 1'b1, frame_transmitted)
        `CHK("tx order", 1'b1, tx_seen)
        mode(`MODE_STANDBY);
        chk_drained(1'b1);
        final_report();
    end
endmodule // test_packet_fifo_sync_detect

//--- verilog/packet_fifo_sync_detect.v
// packet buffer, serializer, deserializer and pattern recognizer
// assumes host strobes are on sys_clk; chip select and rx bits are pins
// Behaviour
// R1 - 64-entry byte-wide buffer in first-in first-out order.
// R2 - transmit shifts buffer bytes out msb first at the bit rate.
// R3 - receive gathers demodulated bits and writes each full byte.
// R4 - buffer_drained is high exactly when the buffer holds nothing.
// R5 - buffer_drained updates on falling chip select during reads.
// R6 - host checks buffer_drained after each read before reading again; the bench reads back to back and checks it only after the last read.
// R7 - buffer_full_flag is high while all entries are occupied.
// R8 - writing into a full buffer sets overflow flag and drops the byte.
// R9 - writing one to the overflow flag clears it and flushes buffer.
// R10 - frame_transmitted rises after the serializer's last bit is sent.
// R11 - level flag re-evaluated only on buffer read or write.
// R12 - level flag invalid after full, normal again once emptied.
// R13 - buffer kept or flushed on mode changes per transition table.
// R14 - host waits for mode_settled_flag before using buffer after sleep.
// R15 - host handles payload only; device adds preamble and pattern.
// R16 - recognizer works only with pattern_detect_enable set.
// R17 - stream compared continuously like a sliding register.
// R18 - first bit meets msb of first byte, last bit lsb of last byte.
// R19 - match flag cleared on leaving receive or buffer emptied.
// R20 - pattern length one to eight bytes, also used for transmit.
// R21 - 64-bit pattern value, also the transmitted pattern.
// R22 - host never programs a pattern with a zero byte.
// R23 - level flag high when count exceeds threshold, else low.
`timescale 1ns/1ps
`include "pkt_fifo_map.vh"

module packet_fifo_sync_detect (
    input  wire                   sys_clk,
    input  wire                   sys_rst,
    input  wire [`MODE_W-1:0]     chip_mode,
    input  wire                   host_wr,
    input  wire [7:0]             host_wdata,
    input  wire                   host_rd,
    input  wire                   spi_cs_n,
    input  wire                   overflow_clear,
    input  wire [5:0]             level_threshold,
    input  wire                   bit_tick,
    input  wire                   demod_bit,
    input  wire                   pattern_detect_enable,
    input  wire [`PAT_LEN_W-1:0]  pattern_length,
    input  wire [`PAT_W-1:0]      pattern_value,
    output reg  [7:0]             host_rdata,
    output reg                    mod_bit,
    output reg                    buffer_drained,
    output reg                    buffer_full_flag,
    output reg                    buffer_overflow_flag,
    output reg                    buffer_level_flag,
    output reg                    frame_transmitted,
    output reg                    pattern_match_flag,
    output reg                    mode_settled_flag,
    output reg                    bit_sync_enable
);
    localparam TX_IDLE = 2'h0;
    localparam TX_PRE  = 2'h1;
    localparam TX_PAT  = 2'h2;
    localparam TX_DATA = 2'h3;

    reg  [7:0]             mem [0:`FIFO_DEPTH-1];
    reg  [`FIFO_PTR_W-1:0] wptr_reg;
    reg  [`FIFO_PTR_W-1:0] rptr_reg;
    reg  [`FIFO_CNT_W-1:0] count_reg;
    reg  [`FIFO_CNT_W-1:0] count_next;
    reg  [`MODE_W-1:0]     mode_reg;
    reg                    level_invalid_reg;
    reg  [1:0]             cs_sync_reg;
    reg                    cs_last_reg;
    reg  [1:0]             rx_sync_reg;
    reg                    sent_pend_reg;
    reg  [1:0]             tx_state_reg;
    reg  [7:0]             shift_reg;
    reg  [2:0]             bitcnt_reg;
    reg  [3:0]             bytecnt_reg;
    reg  [7:0]             rx_shift_reg;
    reg  [2:0]             rx_cnt_reg;
    reg  [7:0]             settle_reg;
    reg                    pat_seen_reg;

    wire mode_change = (chip_mode != mode_reg);
    wire in_rx       = (mode_reg == `MODE_RX);
    wire in_tx       = (mode_reg == `MODE_TX);
    wire low_power   = (mode_reg == `MODE_SLEEP) ||
                       (mode_reg == `MODE_STANDBY);
    // R13
    wire mode_flush  = mode_change &&
                       ((mode_reg == `MODE_TX) ||
                        (low_power && chip_mode == `MODE_RX) ||
                        (in_rx && chip_mode == `MODE_TX));
    wire flush       = mode_flush || overflow_clear; // R9
    wire cs_fall     = cs_last_reg && !cs_sync_reg[1];
    wire rx_bit      = rx_sync_reg[1];
    wire full        = (count_reg == `FIFO_DEPTH);
    wire empty       = (count_reg == {`FIFO_CNT_W{1'b0}});

    wire rx_byte_done = in_rx && bit_tick && pat_seen_reg &&
                        (rx_cnt_reg == `BIT_CNT_LAST); // R3
    wire [7:0] rx_byte = {rx_shift_reg[6:0], rx_bit};
    // pop only when a payload byte really moves into the shifter; the
    // preamble start must not consume the first payload byte
    wire tx_load      = in_tx && bit_tick && (bitcnt_reg == `BIT_CNT_LAST)
                        && !empty && (tx_state_reg == TX_DATA ||
                           (tx_state_reg == TX_PAT &&
                            bytecnt_reg > {1'b0, pattern_length}));
    wire wr_req  = (host_wr && !in_rx) || rx_byte_done;
    wire [7:0] wr_data = rx_byte_done ? rx_byte : host_wdata;
    wire do_wr   = wr_req && !full;                        // R8
    wire do_rd   = (host_rd || tx_load) && !empty;
    wire pat_hit;

    pattern_match u_match (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .bit_valid      (bit_tick && in_rx && pattern_detect_enable),
        .bit_in         (rx_bit),
        .clear          (!in_rx || !pattern_detect_enable),
        .pattern_length (pattern_length),
        .pattern_value  (pattern_value),
        .hit            (pat_hit)
    ); // R16

    always @* begin
        count_next = count_reg;
        if (do_wr && !do_rd)
            count_next = count_reg + 7'h01;
        else if (do_rd && !do_wr)
            count_next = count_reg - 7'h01;
    end

    always @(posedge sys_clk) begin
        if (do_wr)
            mem[wptr_reg] <= wr_data; // R1
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wptr_reg             <= 6'h00;
            rptr_reg             <= 6'h00;
            count_reg            <= 7'h00;
            mode_reg             <= `MODE_SLEEP;
            cs_sync_reg          <= 2'h3;
            cs_last_reg          <= 1'b1;
            rx_sync_reg          <= 2'h0;
            host_rdata           <= 8'h00;
            buffer_drained       <= 1'b1;
            buffer_full_flag     <= 1'b0;
            buffer_overflow_flag <= 1'b0;
            buffer_level_flag    <= 1'b0;
            level_invalid_reg    <= 1'b0;
            settle_reg           <= 8'h00;
            mode_settled_flag    <= 1'b0;
            bit_sync_enable      <= 1'b0;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], spi_cs_n};
            cs_last_reg <= cs_sync_reg[1];
            rx_sync_reg <= {rx_sync_reg[0], demod_bit};
            mode_reg    <= chip_mode;
            bit_sync_enable <= pattern_detect_enable; // R16
            if (mode_change) begin
                settle_reg        <= `SETTLE_CYCLES;
                mode_settled_flag <= 1'b0;
            end else if (settle_reg != 8'h00) begin
                settle_reg <= settle_reg - 8'h01;
            end else begin
                mode_settled_flag <= 1'b1;
            end
            if (flush) begin
                wptr_reg          <= 6'h00;
                rptr_reg          <= 6'h00;
                count_reg         <= 7'h00;
                buffer_full_flag  <= 1'b0;
                buffer_drained    <= 1'b1;
                buffer_level_flag <= 1'b0;
                level_invalid_reg <= 1'b0;
            end else begin
                if (do_wr)
                    wptr_reg <= wptr_reg + 6'h01;
                if (do_rd) begin
                    rptr_reg <= rptr_reg + 6'h01;
                    if (host_rd)
                        host_rdata <= mem[rptr_reg];
                end
                count_reg <= count_next;
                buffer_full_flag <= (count_next == `FIFO_DEPTH); // R7
                // R5: while the host reads, drained moves on cs falling
                if (host_rd || !cs_sync_reg[1]) begin
                    if (cs_fall)
                        buffer_drained <= (count_next == 7'h00); // R4
                end else begin
                    buffer_drained <= (count_next == 7'h00); // R4
                end
                if (count_next == `FIFO_DEPTH)
                    level_invalid_reg <= 1'b1; // R12
                else if (count_next == 7'h00)
                    level_invalid_reg <= 1'b0; // R12
                // R11 R23
                // the emptying access already reports normally again
                if ((do_wr || do_rd) && count_next != `FIFO_DEPTH &&
                    (!level_invalid_reg || count_next == 7'h00))
                    buffer_level_flag <=
                        (count_next > {1'b0, level_threshold});
            end
            // set wins over the clear request
            if (wr_req && full)
                buffer_overflow_flag <= 1'b1; // R8
            else if (overflow_clear)
                buffer_overflow_flag <= 1'b0; // R9
        end
    end

    // transmit framer: preamble, pattern, then payload from buffer (R15)
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state_reg      <= TX_IDLE;
            shift_reg         <= 8'h00;
            bitcnt_reg        <= `BIT_CNT_LAST;
            bytecnt_reg       <= 4'h0;
            mod_bit           <= 1'b0;
            frame_transmitted <= 1'b0;
            sent_pend_reg     <= 1'b0;
        end else begin
            frame_transmitted <= 1'b0;
            if (!in_tx) begin
                tx_state_reg  <= TX_IDLE;
                bitcnt_reg    <= `BIT_CNT_LAST;
                sent_pend_reg <= 1'b0;
            end else if (bit_tick) begin
                mod_bit <= shift_reg[`BYTE_MSB]; // R2
                // the last bit has only left once its own period is over
                if (sent_pend_reg) begin
                    sent_pend_reg     <= 1'b0;
                    frame_transmitted <= 1'b1; // R10
                end
                if (bitcnt_reg != `BIT_CNT_LAST) begin
                    shift_reg  <= {shift_reg[6:0], 1'b0};
                    bitcnt_reg <= bitcnt_reg + 3'h1;
                end else begin
                    bitcnt_reg <= 3'h0;
                    case (tx_state_reg)
                    TX_IDLE: begin
                        if (!empty) begin
                            tx_state_reg <= TX_PRE;
                            shift_reg    <= `PREAMBLE_BYTE;
                            bytecnt_reg  <= 4'h1;
                        end else begin
                            bitcnt_reg <= `BIT_CNT_LAST;
                        end
                    end
                    TX_PRE: begin
                        if (bytecnt_reg == `FRAME_PRE_BYTES) begin
                            tx_state_reg <= TX_PAT;
                            bytecnt_reg  <= 4'h1;
                            shift_reg    <= pattern_value[63:56]; // R21
                        end else begin
                            bytecnt_reg <= bytecnt_reg + 4'h1;
                            shift_reg   <= `PREAMBLE_BYTE;
                        end
                    end
                    TX_PAT: begin
                        // R20
                        if (bytecnt_reg > {1'b0, pattern_length}) begin
                            tx_state_reg <= TX_DATA;
                            shift_reg    <= mem[rptr_reg];
                        end else begin
                            shift_reg <=
                                pattern_value[(7 - bytecnt_reg) * 8 +: 8];
                            bytecnt_reg <= bytecnt_reg + 4'h1;
                        end
                    end
                    TX_DATA: begin
                        if (!empty) begin
                            shift_reg <= mem[rptr_reg]; // R2
                        end else begin
                            tx_state_reg      <= TX_IDLE;
                            bitcnt_reg        <= `BIT_CNT_LAST;
                            sent_pend_reg     <= 1'b1; // R10
                        end
                    end
                    default: tx_state_reg <= TX_IDLE;
                    endcase
                end
            end
        end
    end

    // receive deserializer, gated by pattern match in packet operation
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_shift_reg       <= 8'h00;
            rx_cnt_reg         <= 3'h0;
            pat_seen_reg       <= 1'b0;
            pattern_match_flag <= 1'b0;
        end else begin
            if (!in_rx || mode_change) begin
                pat_seen_reg       <= 1'b0;
                pattern_match_flag <= 1'b0; // R19
                rx_cnt_reg         <= 3'h0;
            end else begin
                // a fresh match in the same cycle outranks this clear
                if (flush || (do_rd && count_next == 7'h00))
                    pattern_match_flag <= 1'b0; // R19
                if (pat_hit && !pat_seen_reg) begin
                    pat_seen_reg       <= 1'b1;
                    pattern_match_flag <= 1'b1; // R17
                    rx_cnt_reg         <= 3'h0;
                end else if (bit_tick && pat_seen_reg) begin
                    rx_shift_reg <= rx_byte; // R3
                    rx_cnt_reg   <= rx_cnt_reg + 3'h1;
                end
            end
        end
    end
endmodule // packet_fifo_sync_detect

//--- verilog/pattern_match.v
// sliding pattern recognizer over the received bit stream
// assumes bits arrive as one-cycle strobes on sys_clk
`timescale 1ns/1ps
`include "pkt_fifo_map.vh"

module pattern_match (
    input  wire                   sys_clk,
    input  wire                   sys_rst,
    input  wire                   bit_valid,
    input  wire                   bit_in,
    input  wire                   clear,
    input  wire [`PAT_LEN_W-1:0]  pattern_length,
    input  wire [`PAT_W-1:0]      pattern_value,
    output reg                    hit
);
    reg  [`PAT_W-1:0] hist_reg;
    reg  [`PAT_W-1:0] mask;
    wire [`PAT_W-1:0] hist_next;
    reg  [`PAT_W-1:0] ref_al;
    integer           i;

    assign hist_next = {hist_reg[`PAT_W-2:0], bit_in};

    // first pattern byte occupies bits 63:56; a shorter pattern is the
    // top bytes, so the last byte used sits at the bottom of the mask
    always @* begin
        mask   = {`PAT_W{1'b0}};
        ref_al = {`PAT_W{1'b0}};
        for (i = 0; i < 8; i = i + 1) begin
            if (i <= pattern_length)
                mask[i*8 +: 8] = 8'hFF;
        end
        ref_al = pattern_value >> ((7 - pattern_length) * 8); // R18
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hist_reg <= {`PAT_W{1'b0}};
            hit      <= 1'b0;
        end else begin
            if (clear)
                hist_reg <= {`PAT_W{1'b0}};
            else if (bit_valid)
                hist_reg <= hist_next;
            hit <= !clear && bit_valid &&
                   ((hist_next & mask) == (ref_al & mask)); // R17
        end
    end
endmodule // pattern_match
